// *** rtl/spf_frame_timing.sv ***
// segment panel frame timing: frame rate chain, frame-aligned data
// transfer, frame counter, blink, blank and the animation machine.
// assumes an APB master on clk and a slow free-running panel clock that
// arrives as a pin and is oversampled here.
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module spf_frame_timing #(
  parameter int ADDR_W = 12,
  parameter int SEG_W = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic lowFreqClock,
  output logic panelEnable,
  output logic [4:0] contrastLevel,
  output logic contrastRefGround,
  output logic panelSupplyBoost,
  output logic boosterEnable,
  output logic boostTick,
  output logic frame_boundary_update,
  output logic counterEvent,
  output logic directBias,
  output logic [4*SEG_W-1:0] segOut,
  output logic irq
);

  // ****************************************
  // registers
  // ****************************************
  logic [31:0] ctrlReg, dispReg, clkReg, baReg;
  logic [SEG_W-1:0] patFirst, patSecond;
  logic [SEG_W-1:0] segReg [4];
  logic irqFlag, irqEnable;
  logic [31:0] readData;
  logic decodeOk, wrEn, shadowWr, patWr;

  assign wrEn = psel && penable && pready && pwrite;
  assign patWr = wrEn && (paddr[11:0] == spf_pkg::OFF_PAT_FIRST ||
                          paddr[11:0] == spf_pkg::OFF_PAT_SECOND);
  // segment data, pattern and BACTRL writes go through the frame transfer
  assign shadowWr = wrEn && (patWr || paddr[11:0] == spf_pkg::OFF_BACTRL ||
    (paddr[11:0] >= spf_pkg::OFF_SEGD0 && paddr[11:0] <= spf_pkg::OFF_SEGD3));

  // live (waveform side) copies
  logic [SEG_W-1:0] segLive [4];
  logic [SEG_W-1:0] shiftFirst, shiftSecond;
  logic [31:0] baLive;
  logic pending, transfer, blinkPhase;
  logic [3:0] animStep;

  // ****************************************
  // APB slave: one wait-free access phase
  // ****************************************
  // read mux; unmapped addresses read zero and raise pslverr
  always_comb begin
    readData = 32'h0000_0000;
    decodeOk = 1'b1;
    unique case (paddr[11:0])
      spf_pkg::OFF_CTRL: readData = ctrlReg;
      spf_pkg::OFF_DISP: readData = dispReg;
      spf_pkg::OFF_CLK: readData = clkReg;
      spf_pkg::OFF_BACTRL: readData = baReg;
      spf_pkg::OFF_STATUS: begin
        readData[3:0] = animStep;
        readData[spf_pkg::ST_PHASE] = blinkPhase;
      end
      spf_pkg::OFF_PAT_FIRST: readData[SEG_W-1:0] = patFirst;
      spf_pkg::OFF_PAT_SECOND: readData[SEG_W-1:0] = patSecond;
      spf_pkg::OFF_IF: readData[0] = irqFlag;
      spf_pkg::OFF_IFS, spf_pkg::OFF_IFC: readData = 32'h0000_0000;
      spf_pkg::OFF_IEN: readData[0] = irqEnable;
      default: begin
        if (paddr[11:0] >= spf_pkg::OFF_SEGD0 &&
            paddr[11:0] <= spf_pkg::OFF_SEGD3 && paddr[1:0] == 2'h0) begin
          readData[SEG_W-1:0] = segReg[paddr[3:2]];
        end else begin
          decodeOk = 1'b0;
        end
      end
    endcase
  end

  // answer is prepared in the setup cycle so all bus outputs are flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !decodeOk;
      prdata <= (psel && !penable && !pwrite) ? readData : 32'h0000_0000;
    end
  end

  // software registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrlReg <= 32'h0000_0000;
      dispReg <= {27'h0, spf_pkg::LEVEL_RESET};
      clkReg <= 32'h0000_0000;
      baReg <= 32'h0000_0000;
      patFirst <= '0;
      patSecond <= '0;
      irqEnable <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        segReg[i] <= '0;
      end
    end else if (wrEn) begin
      unique case (paddr[11:0])
        spf_pkg::OFF_CTRL: ctrlReg <= pwdata;
        spf_pkg::OFF_DISP: dispReg <= pwdata;
        spf_pkg::OFF_CLK: clkReg <= pwdata;
        spf_pkg::OFF_BACTRL: baReg <= pwdata;
        spf_pkg::OFF_PAT_FIRST: patFirst <= pwdata[SEG_W-1:0];
        spf_pkg::OFF_PAT_SECOND: patSecond <= pwdata[SEG_W-1:0];
        spf_pkg::OFF_IEN: irqEnable <= pwdata[0];
        default: begin
          if (paddr[11:0] >= spf_pkg::OFF_SEGD0 &&
              paddr[11:0] <= spf_pkg::OFF_SEGD3 && paddr[1:0] == 2'h0) begin
            segReg[paddr[3:2]] <= pwdata[SEG_W-1:0];
          end
        end
      endcase
    end
  end

  // ****************************************
  // low clock sampling and rate chain
  // ****************************************
  logic lfS1, lfS2, lfS3, lfLevel, lfTick;
  logic [6:0] preCount, boostCount, preLast, boostMask;
  logic preTick, panelTick;
  logic [2:0] divCount;
  logic [3:0] frameCount;

  // three stages; a level counts once stages two and three agree
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lfS1 <= 1'b0;
      lfS2 <= 1'b0;
      lfS3 <= 1'b0;
      lfLevel <= 1'b0;
      lfTick <= 1'b0;
    end else begin
      lfS1 <= lowFreqClock;
      lfS2 <= lfS1;
      lfS3 <= lfS2;
      if (lfS2 == lfS3) begin
        lfLevel <= lfS3;
      end
      lfTick <= (lfS2 == lfS3) && lfS3 && !lfLevel;
    end
  end

  assign preLast = 7'((spf_pkg::PRESC_BASE <<
                   clkReg[spf_pkg::CLK_PRESC_LO +: 2]) - 7'h01);
  assign boostMask = 7'((8'h01 << clkReg[spf_pkg::CLK_BOOSTDIV_LO +: 3])
                   - 8'h01);

  // booster update pulse: one low clock in 2^n
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      boostCount <= 7'h00;
      boostTick <= 1'b0;
    end else begin
      boostTick <= lfTick && ((boostCount & boostMask) == 7'h00);
      if (lfTick) begin
        boostCount <= boostCount + 7'h01;
      end
    end
  end

  // prescaler, frame divider and multiplex divider in one chain
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      preCount <= 7'h00;
      preTick <= 1'b0;
      divCount <= 3'h0;
      panelTick <= 1'b0;
      frameCount <= 4'h0;
      frame_boundary_update <= 1'b0;
    end else begin
      preTick <= 1'b0;
      panelTick <= 1'b0;
      frame_boundary_update <= 1'b0;
      if (lfTick) begin
        // a narrower setting wraps at once instead of running to 127
        preCount <= (preCount >= preLast) ? 7'h00 : preCount + 7'h01;
        preTick <= preCount >= preLast;
      end
      if (preTick) begin
        divCount <= (divCount >= clkReg[spf_pkg::CLK_FRAME_DIVIDER_LO +: 3]) ?
                    3'h0 : divCount + 3'h1;
        panelTick <= divCount >= clkReg[spf_pkg::CLK_FRAME_DIVIDER_LO +: 3];
      end
      if (panelTick && ctrlReg[spf_pkg::CTRL_EN]) begin
        if (frameCount >= spf_pkg::frame_last(
            dispReg[spf_pkg::DISP_MUX_LO +: 3])) begin
          frameCount <= 4'h0;
          frame_boundary_update <= 1'b1;
        end else begin
          frameCount <= frameCount + 4'h1;
        end
      end
    end
  end

  // ****************************************
  // frame counter
  // ****************************************
  logic frame_counter_enable, fcEnPrev, counter_event_update;
  logic [2:0] fcPre;
  logic [5:0] fcCount;
  logic fcStep;

  assign frame_counter_enable = baReg[spf_pkg::BA_FRAME_COUNTER_ENABLE];
  // decrement on every 2^prescale-th frame start
  assign fcStep = frame_boundary_update &&
    ((fcPre & 3'((4'h1 << baReg[spf_pkg::BA_PRESC_LO +: 2]) - 4'h1)) ==
     3'h0);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fcEnPrev <= 1'b0;
      fcPre <= 3'h0;
      fcCount <= 6'h00;
      counter_event_update <= 1'b0;
    end else begin
      fcEnPrev <= frame_counter_enable;
      counter_event_update <= 1'b0;
      if (frame_counter_enable && !fcEnPrev) begin
        fcCount <= baReg[spf_pkg::BA_TOP_LO +: 6];
        fcPre <= 3'h0;
      end else if (frame_counter_enable && frame_boundary_update) begin
        fcPre <= fcPre + 3'h1;
        if (fcStep) begin
          if (fcCount == 6'h00) begin
            fcCount <= baReg[spf_pkg::BA_TOP_LO +: 6];
            counter_event_update <= 1'b1;
          end else begin
            fcCount <= fcCount - 6'h01;
          end
        end
      end
    end
  end

  // ****************************************
  // frame-aligned transfer
  // ****************************************
  always_comb begin
    transfer = 1'b0;
    if (pending) begin
      unique case (ctrlReg[spf_pkg::CTRL_UPD_LO +: 2])
        spf_pkg::UPD_EVENT: transfer = counter_event_update;
        spf_pkg::UPD_FRAME: transfer = frame_boundary_update;
        default: transfer = 1'b1;
      endcase
      // a stopped panel has no frames to wait for
      if (!ctrlReg[spf_pkg::CTRL_EN]) begin
        transfer = 1'b1;
      end
    end
  end

  // a write in the transfer cycle keeps pending so it is not lost
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pending <= 1'b0;
    end else begin
      pending <= shadowWr || (pending && !transfer);
    end
  end

  // live copies; the animation registers reload with the rest
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      baLive <= 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
        segLive[i] <= '0;
      end
    end else if (transfer) begin
      baLive <= baReg;
      for (int i = 0; i < 4; i++) begin
        segLive[i] <= segReg[i];
      end
    end
  end

  // ****************************************
  // blink and animation
  // ****************************************
  logic stepOdd;
  assign stepOdd = !animStep[0];

  function automatic logic [SEG_W-1:0] shift_pat(input logic [SEG_W-1:0] p,
                                                 input logic [1:0] mode);
    case (mode)
      spf_pkg::SHIFT_LEFT: shift_pat = {p[SEG_W-2:0], p[SEG_W-1]};
      spf_pkg::SHIFT_RIGHT: shift_pat = {p[0], p[SEG_W-1:1]};
      default: shift_pat = p; // no shift, and the reserved code
    endcase
  endfunction

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      blinkPhase <= 1'b0;
    end else if (!baLive[spf_pkg::BA_BLINK] || !frame_counter_enable) begin
      blinkPhase <= 1'b0;
    end else if (counter_event_update) begin
      blinkPhase <= !blinkPhase;
    end
  end

  // the next state's parity picks which copy shifts
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      animStep <= 4'h0;
      shiftFirst <= '0;
      shiftSecond <= '0;
    end else begin
      if (patWr) begin
        animStep <= 4'h0;
      end else if (counter_event_update && baLive[spf_pkg::BA_ANIM]) begin
        animStep <= animStep + 4'h1;
      end
      if (transfer) begin
        shiftFirst <= patFirst;
        shiftSecond <= patSecond;
      end else if (counter_event_update && baLive[spf_pkg::BA_ANIM] && !patWr) begin
        if (stepOdd) begin
          shiftFirst <= shift_pat(shiftFirst,
                                  baLive[spf_pkg::BA_SHA_LO +: 2]);
        end else begin
          shiftSecond <= shift_pat(shiftSecond,
                                   baLive[spf_pkg::BA_SHB_LO +: 2]);
        end
      end
    end
  end

  // ****************************************
  // outputs, flag and interrupt
  // ****************************************
  logic [SEG_W-1:0] animPat;
  assign animPat = !baLive[spf_pkg::BA_ANIM] ? '0 :
    baLive[spf_pkg::BA_COMBINE] ? (shiftFirst | shiftSecond) :
                                  (shiftFirst & shiftSecond);

  // outside direct mode data 0 carries the animation on common zero and blank and blink force off
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      segOut <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (ctrlReg[spf_pkg::CTRL_DIRECT]) begin
          segOut[i*SEG_W +: SEG_W] <= segLive[i];
        end else if (baLive[spf_pkg::BA_BLANK] || blinkPhase) begin
          segOut[i*SEG_W +: SEG_W] <= '0;
        end else if (i == 0) begin
          segOut[i*SEG_W +: SEG_W] <= segLive[i] | animPat;
        end else begin
          segOut[i*SEG_W +: SEG_W] <= segLive[i];
        end
      end
    end
  end

  // set beats clear; the event pulse lasts one cycle so it sets once
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irqFlag <= 1'b0;
    end else if (counter_event_update ||
                 (wrEn && paddr[11:0] == spf_pkg::OFF_IFS && pwdata[0])) begin
      irqFlag <= 1'b1;
    end else if (wrEn && paddr[11:0] == spf_pkg::OFF_IFC && pwdata[0]) begin
      irqFlag <= 1'b0;
    end
  end

  // static controls and pulses, all registered
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
      counterEvent <= 1'b0;
      panelEnable <= 1'b0;
      contrastLevel <= spf_pkg::LEVEL_RESET;
      contrastRefGround <= 1'b0;
      panelSupplyBoost <= 1'b0;
      boosterEnable <= 1'b0;
      directBias <= 1'b0;
    end else begin
      irq <= irqFlag && irqEnable;
      counterEvent <= counter_event_update;
      panelEnable <= ctrlReg[spf_pkg::CTRL_EN];
      contrastLevel <= dispReg[spf_pkg::DISP_LEVEL_LO +: 5];
      contrastRefGround <= dispReg[spf_pkg::DISP_REF];
      panelSupplyBoost <= dispReg[spf_pkg::DISP_SUPPLY];
      boosterEnable <= clkReg[spf_pkg::CLK_BOOSTEN];
      directBias <= ctrlReg[spf_pkg::CTRL_DIRECT];
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_irq_gated: assert property ((irqFlag && irqEnable) |=> irq)
    else $error("interrupt not raised for enabled flag");
  a_flag_on_event: assert property (counter_event_update |=> irqFlag ##0 counterEvent)
    else $error("event did not set flag");
  a_event_reload: assert property (counter_event_update |-> fcCount ==
    baReg[spf_pkg::BA_TOP_LO +: 6] && $past(fcCount) == 6'h00)
    else $error("event without reload from zero");
  a_counter_idle: assert property (!frame_counter_enable |=> !counter_event_update)
    else $error("event while counter disabled");
  a_step_clear: assert property (patWr |=> animStep == 4'h0)
    else $error("pattern write did not clear step");
  a_blink_toggle: assert property ((counter_event_update && frame_counter_enable &&
    baLive[spf_pkg::BA_BLINK] && !transfer) |=>
    blinkPhase != $past(blinkPhase))
    else $error("blink did not toggle on event");
  a_policy_event: assert property ((pending && counter_event_update && !shadowWr &&
    ctrlReg[spf_pkg::CTRL_UPD_LO +: 2] == spf_pkg::UPD_EVENT) |=> !pending)
    else $error("event transfer not taken");
  a_blank_off: assert property ((baLive[spf_pkg::BA_BLANK] &&
    !ctrlReg[spf_pkg::CTRL_DIRECT]) |=> segOut == '0)
    else $error("blanked segments not off");
  a_frame_step: assert property (frame_boundary_update |-> $past(panelTick))
    else $error("frame start without panel tick");

  c_event: cover property (counter_event_update ##1 irq);
  c_anim_wrap: cover property (animStep == 4'hF ##[1:1000] animStep == 4'h0);
  c_frame_xfer: cover property (transfer && frame_boundary_update);

endmodule // spf_frame_timing

`default_nettype wire

// *** inc/spf_pkg.sv ***
// package for the segment panel frame timing block: register map, field
// positions, reset values and divider constants.
// assumes one core clock and a 32-bit APB register bus.
package spf_pkg;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_DISP = 12'h004;
  localparam logic [11:0] OFF_CLK = 12'h008;
  localparam logic [11:0] OFF_BACTRL = 12'h00C;
  localparam logic [11:0] OFF_STATUS = 12'h010;
  localparam logic [11:0] OFF_PAT_FIRST = 12'h014;
  localparam logic [11:0] OFF_PAT_SECOND = 12'h018;
  localparam logic [11:0] OFF_IF = 12'h01C;
  localparam logic [11:0] OFF_IFS = 12'h020;
  localparam logic [11:0] OFF_IFC = 12'h024;
  localparam logic [11:0] OFF_IEN = 12'h028;
  localparam logic [11:0] OFF_SEGD0 = 12'h040;
  localparam logic [11:0] OFF_SEGD3 = 12'h04C;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CTRL_EN = 0;
  localparam int CTRL_UPD_LO = 1;
  localparam int CTRL_DIRECT = 23;
  localparam int DISP_LEVEL_LO = 0;
  localparam int DISP_MUX_LO = 8;
  localparam int DISP_REF = 16;
  localparam int DISP_SUPPLY = 17;
  localparam int CLK_PRESC_LO = 0;
  localparam int CLK_FRAME_DIVIDER_LO = 4;
  localparam int CLK_BOOSTDIV_LO = 8;
  localparam int CLK_BOOSTEN = 12;
  localparam int BA_BLINK = 0;
  localparam int BA_BLANK = 1;
  localparam int BA_FRAME_COUNTER_ENABLE = 2;
  localparam int BA_SHA_LO = 3;
  localparam int BA_SHB_LO = 5;
  localparam int BA_COMBINE = 7;
  localparam int BA_ANIM = 8;
  localparam int BA_PRESC_LO = 16;
  localparam int BA_TOP_LO = 18;
  localparam int ST_PHASE = 8;

  // ****************************************
  // reset values and encodings
  // ****************************************
  localparam logic [4:0] LEVEL_RESET = 5'h1F;
  localparam logic [1:0] UPD_SOON = 2'h0;
  localparam logic [1:0] UPD_EVENT = 2'h1;
  localparam logic [1:0] UPD_FRAME = 2'h2;
  localparam logic [1:0] SHIFT_LEFT = 2'h1;
  localparam logic [1:0] SHIFT_RIGHT = 2'h2;
  localparam logic [6:0] PRESC_BASE = 7'h10;

  // panel ticks per frame, less one, by multiplex mode
  function automatic logic [3:0] frame_last(input logic [2:0] mux);
    case (mux)
      3'h0: frame_last = 4'h1;
      3'h1: frame_last = 4'h3;
      3'h2: frame_last = 4'h5;
      3'h3: frame_last = 4'h7;
      3'h4: frame_last = 4'hB;
      default: frame_last = 4'hF;
    endcase
  endfunction

endpackage

// *** verif/spf_lf_source.sv ***
// far-side model: the slow panel clock that feeds the timing chain.
// assumes a core clock of 10 ns; a half period of 5 clocks keeps the
// pin slow enough for the three-flop oversampler.
`timescale 1ns/10ps
`default_nettype none
module spf_lf_source #(
  parameter int HALF_NS = 50
) (
  output logic lowFreqClock
);
  // free running; phase offset so its edges never meet the core edges
  initial begin
    lowFreqClock = 1'h0;
    #3;
    forever #HALF_NS lowFreqClock = ~lowFreqClock;
  end
endmodule // spf_lf_source
`default_nettype wire

// *** verif/segment_panel_frame_timing_test.sv ***
// self-checking bench for the segment panel frame timing block.
// assumes spf_pkg and the low clock model; the low clock period is 10
// core clocks, so every expected gap is a multiple of ten.
`timescale 1ns/10ps
`default_nettype none
module segment_panel_frame_timing_test;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, lowFreqClock;
  logic panelEnable, contrastRefGround, panelSupplyBoost, boosterEnable;
  logic boostTick, frame_boundary_update, counterEvent, directBias, irq, errv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv, segOut;
  logic [4:0] contrastLevel;
  int nMismatch, samplesChecked, c, i;
  int divs[6] = '{2, 4, 6, 8, 12, 16};

  spf_frame_timing u_spf_frame_timing (.clk(clk), .rst_b(rst_b),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lowFreqClock(lowFreqClock), .panelEnable(panelEnable),
    .contrastLevel(contrastLevel), .contrastRefGround(contrastRefGround),
    .panelSupplyBoost(panelSupplyBoost), .boosterEnable(boosterEnable),
    .boostTick(boostTick), .frame_boundary_update(frame_boundary_update),
    .counterEvent(counterEvent), .directBias(directBias),
    .segOut(segOut), .irq(irq));
  spf_lf_source u_spf_lf_source (.lowFreqClock(lowFreqClock));

  always #5 clk = ~clk;

  // ****************************************
  // access and checking tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    samplesChecked++;
    if (seen !== exp) begin
      nMismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // apb cycle; values read just after the edge are the pre-edge ones
  // no wait limit here: only the watchdog ends a stuck access
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
    end while (pready !== 1'h1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  function automatic logic pick(input int s);
    pick = (s == 0) ? frame_boundary_update : (s == 1) ? counterEvent : boostTick;
  endfunction

  // bounded wait for the next pulse of the chosen strobe
  task automatic waitp(input int s);
    int k;
    k = 0;
    while (pick(s) !== 1'h1 && k < 9000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 9000) begin
      nMismatch++;
    end
  endtask

  // clocks between two successive pulses of the chosen strobe
  task automatic gap(input int s, output int n);
    waitp(s);
    @(posedge clk);
    n = 1;
    while (pick(s) !== 1'h1 && n < 9000) begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samplesChecked, nMismatch);
    if (nMismatch == 0 && samplesChecked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // watchdog sized well above the roughly 40k clocks the tests need
  initial begin
    repeat (80000) @(posedge clk);
    nMismatch++;
    report_and_stop();
  end

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    clk = 1'h0;
    rst_b = 1'h0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (3) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    chk("level", {27'h0, contrastLevel}, 32'h1F);
    apb(1'h1, spf_pkg::OFF_DISP, 32'h0003001F);
    // the pins follow the register one clock after the write lands
    repeat (2) @(posedge clk);
    chk("ref", {31'h0, contrastRefGround}, 32'h1);
    chk("supply", {31'h0, panelSupplyBoost}, 32'h1);
    apb(1'h0, 12'h0FC, 32'h0);
    chk("unmapped", {31'h0, errv}, 32'h1);
    $display("test registers done");
    // mux modes, then slowest prescale and largest divider; panel is
    // stopped around each clock change so the frame counter never moves live
    for (i = 0; i < 8; i++) begin
      apb(1'h1, spf_pkg::OFF_CTRL, 32'h0);
      apb(1'h1, spf_pkg::OFF_CLK,
          (i == 6) ? 32'h3 : (i == 7) ? 32'h70 : 32'h0);
      apb(1'h1, spf_pkg::OFF_DISP, 32'h1F | ((i < 6 ? i : 0) << 8));
      apb(1'h1, spf_pkg::OFF_CTRL, 32'h1);
      gap(0, c);
      chk("frame", c,
          160 * divs[i < 6 ? i : 0] * ((i > 5) ? 8 : 1));
    end
    chk("enable", {31'h0, panelEnable}, 32'h1);
    $display("test frame rate done");
    for (i = 0; i < 4; i += 3) begin
      apb(1'h1, spf_pkg::OFF_CLK, 32'h1000 | (i << 8));
      gap(2, c);
      chk("boost", c, 10 << i);
    end
    chk("booster", {31'h0, boosterEnable}, 32'h1);
    $display("test boost done");
    apb(1'h1, spf_pkg::OFF_BACTRL, 32'h4 | (1 << 16) | (2 << 18));
    gap(1, c);
    chk("event prescaled", c, 1920);
    apb(1'h1, spf_pkg::OFF_BACTRL, 32'h4);
    gap(1, c);
    chk("event", c, 320);
    apb(1'h0, spf_pkg::OFF_IF, 32'h0);
    chk("flag", rdv & 32'h1, 32'h1);
    chk("irq masked", {31'h0, irq}, 32'h0);
    apb(1'h1, spf_pkg::OFF_IEN, 32'h1);
    apb(1'h0, spf_pkg::OFF_IEN, 32'h0);
    chk("irq", {31'h0, irq}, 32'h1);
    apb(1'h1, spf_pkg::OFF_BACTRL, 32'h0);
    c = 0;
    repeat (700) begin
      @(posedge clk);
      c += counterEvent;
    end
    chk("stopped", c, 0);
    apb(1'h1, spf_pkg::OFF_IFC, 32'h1);
    apb(1'h0, spf_pkg::OFF_IF, 32'h0);
    chk("flag clear", rdv & 32'h1, 32'h0);
    apb(1'h1, spf_pkg::OFF_IFS, 32'h1);
    apb(1'h0, spf_pkg::OFF_IF, 32'h0);
    chk("flag set", rdv & 32'h1, 32'h1);
    $display("test frame counter done");
    apb(1'h1, spf_pkg::OFF_CTRL, 32'h3);
    apb(1'h1, spf_pkg::OFF_BACTRL, 32'h4);
    apb(1'h1, spf_pkg::OFF_SEGD0, 32'h5A);
    repeat (3) @(posedge clk);
    chk("held", segOut & 32'hFF, 32'h0);
    waitp(1);
    repeat (3) @(posedge clk);
    chk("on event", segOut & 32'hFF, 32'h5A);
    apb(1'h1, spf_pkg::OFF_CTRL, 32'h1);
    apb(1'h1, spf_pkg::OFF_SEGD0 + 12'h4, 32'hA5);
    repeat (3) @(posedge clk);
    chk("soon", segOut[15:8], 32'hA5);
    apb(1'h1, spf_pkg::OFF_BACTRL, 32'h6);
    repeat (3) @(posedge clk);
    chk("blank", segOut, 32'h0);
    apb(1'h1, spf_pkg::OFF_CTRL, 32'h00800001);
    repeat (3) @(posedge clk);
    chk("direct", {directBias, 23'h0, segOut[15:8]},
        32'h800000A5);
    apb(1'h1, spf_pkg::OFF_CTRL, 32'h1);
    $display("test update done");
    waitp(1);
    apb(1'h1, spf_pkg::OFF_SEGD0, 32'h0);
    apb(1'h1, spf_pkg::OFF_PAT_FIRST, 32'hC0);
    apb(1'h1, spf_pkg::OFF_PAT_SECOND, 32'hC0);
    apb(1'h1, spf_pkg::OFF_BACTRL, 32'h1D4);
    waitp(1);
    repeat (3) @(posedge clk);
    chk("anim", segOut & 32'hFF, 32'hE0);
    apb(1'h0, spf_pkg::OFF_STATUS, 32'h0);
    chk("step", rdv & 32'hF, 32'h1);
    apb(1'h0, spf_pkg::OFF_PAT_FIRST, 32'h0);
    chk("pattern", rdv, 32'hC0);
    apb(1'h1, spf_pkg::OFF_PAT_SECOND, 32'hC0);
    apb(1'h0, spf_pkg::OFF_STATUS, 32'h0);
    chk("step clear", rdv & 32'hF, 32'h0);
    $display("test animation done");
    // blink: start right after an event so none lands among the writes
    waitp(1);
    apb(1'h1, spf_pkg::OFF_SEGD0, 32'h3C);
    apb(1'h1, spf_pkg::OFF_BACTRL, 32'h5);
    waitp(1);
    repeat (3) @(posedge clk);
    chk("blink off", segOut, 32'h0);
    waitp(1);
    repeat (3) @(posedge clk);
    chk("blink on", segOut & 32'hFF, 32'h3C);
    // frame start policy: the write waits for the next frame boundary
    apb(1'h1, spf_pkg::OFF_BACTRL, 32'h4);
    waitp(0);
    apb(1'h1, spf_pkg::OFF_CTRL, 32'h5);
    apb(1'h1, spf_pkg::OFF_SEGD0, 32'h81);
    repeat (3) @(posedge clk);
    chk("frame held", segOut & 32'hFF, 32'h3C);
    waitp(0);
    repeat (3) @(posedge clk);
    chk("frame start", segOut & 32'hFF, 32'h81);
    // left shift with the and combine, ored over segment data
    apb(1'h1, spf_pkg::OFF_CTRL, 32'h1);
    waitp(1);
    apb(1'h1, spf_pkg::OFF_PAT_FIRST, 32'h03);
    apb(1'h1, spf_pkg::OFF_PAT_SECOND, 32'h03);
    apb(1'h1, spf_pkg::OFF_BACTRL, 32'h12C);
    waitp(1);
    repeat (3) @(posedge clk);
    chk("anim and", segOut & 32'hFF, 32'h83);
    $display("test blink and policy done");
    report_and_stop();
  end
endmodule // segment_panel_frame_timing_test
`default_nettype wire
